// File: ptc_params.svh
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
// Summary of operation
// R1: address/control: bits 6:0 address, bit 7 direction
// R2: writing address/control starts one internal access
// R3: host loads data buffer before write request
// R4: read data lands in buffer within 480 ns
// R5: addresses 20H..3FH are slot control bytes
// R6: addresses 40H..5FH are slot idle codes
// R7: control byte field layout fixed
// R8: no substitution: pass or alternate-bit inversion
// R9: no substitution, both selects: invert whole byte
// R10: substitution, select zero low: idle code
// R11: substitution 1/0: A-law milliwatt sequence
// R12: substitution 1/1: mu-law milliwatt sequence
// R13: signalling source honoured only under CAS
// R14: source 0 backplane, 1 alternate bits
// R15: idle code sent msb first
// R16: address/control and data buffer reset zero
// R17: per-slot enable low disables all manipulation
// R18: busy bit high until access completes
// R19: host must set indirect mode bit
// R20: slot counter aligned to transmit frame
`define PTC_OFS_CFG      8'h30
`define PTC_OFS_STATUS   8'h31
`define PTC_OFS_ADDR     8'h32
`define PTC_OFS_DATA     8'h33
`define PTC_DIR_BIT      7
`define PTC_CTRL_BASE    7'h20
`define PTC_CTRL_END     7'h3F
`define PTC_IDLE_BASE    7'h40
`define PTC_IDLE_END     7'h5F
`define PTC_REG_RESET    8'h00
`define PTC_ACCESS_NS    480
`define PTC_CLK_NS       40
`define PTC_ACCESS_CYC   (`PTC_ACCESS_NS / `PTC_CLK_NS)
`define PTC_BIT_SUBSTITUTE_ENABLE     7
`define PTC_BIT_SEL0     6
`define PTC_BIT_SEL1     5
`define PTC_BIT_SIGNALLING_SOURCE_SELECT   4
`endif

// File: ptc_pkg.sv
package ptc_pkg;
    typedef struct packed {
        logic       substitute_enable;
        logic       manip_select_zero;
        logic       manip_select_one;
        logic       signalling_source_select;
        logic [3:0] alt_sig;
    } ptc_ctrl_t;
    typedef struct packed {
        logic [7:0] pcm;
        logic [3:0] sig;
    } ptc_slot_t;
    typedef enum logic [2:0] {
        PTC_IDLE = 3'b001,
        PTC_RUN  = 3'b010,
        PTC_DONE = 3'b100
    } ptc_acc_t;
endpackage : ptc_pkg

// File: ptc_fifo.sv
`timescale 1ns/1ps
module ptc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;
    logic             ready_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_next;

    // full flag is a flop so the source never sees a combinational ready
    assign in_ready  = ready_reg;
    assign wr_next   = wr_reg + (AW+1)'(push);
    assign rd_next   = rd_reg + (AW+1)'(pop);
    assign out_valid = wr_reg != rd_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_reg[AW-1:0]];

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) mem[wr_reg[AW-1:0]] <= in_data;
    end
    // pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            ready_reg <= 1'b1;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            ready_reg <= (wr_next - rd_next) != (AW+1)'(DEPTH);
        end
    end
endmodule : ptc_fifo

// File: ptc_top.sv
`timescale 1ns/1ps
`include "ptc_params.svh"
module ptc_top
    import ptc_pkg::*;
#(
    parameter int SLOTS = 32
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // microprocessor register port
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // configuration from the transmitter
    input  wire logic       cas_mode,
    // backplane transmit stream, one slot per word
    input  wire logic       slot_valid,
    output logic            slot_ready,
    input  wire logic       frame_start,
    input  wire logic [7:0] backplane_tx_pcm_in,
    input  wire logic [3:0] backplane_tx_signalling_in,
    // manipulated stream toward the transmitter
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic      [7:0] tx_pcm_stream,
    output logic      [3:0] tx_sig_stream,
    output logic      [4:0] tx_slot
);
    localparam int ACC_CYC = `PTC_ACCESS_CYC;
    initial begin
        if (SLOTS != 32) $error("slot count fixed at 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // inclusive address window test, shared by both store decodes
    function automatic logic in_win(input logic [6:0] a, input logic [6:0] lo,
                                    input logic [6:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_win

    function automatic logic [7:0] mw_byte(input logic mu, input logic [2:0] ph);
        logic [7:0] b;
        b = 8'h00;
        case (ph[1:0])
            2'h0, 2'h3: b = mu ? 8'h1E : 8'h34;
            default:    b = mu ? 8'h0B : 8'h21;
        endcase
        return {ph[2], b[6:0]};  // second half sets bit 1 (msb)
    endfunction : mw_byte

    function automatic logic [7:0] manip(input ptc_ctrl_t c, input logic [7:0] d,
                                         input logic [7:0] idle, input logic [2:0] ph);
        logic [7:0] r;
        r = d;
        if (!c.substitute_enable) begin
            case ({c.manip_select_zero, c.manip_select_one})
                2'b01:   r = d ^ 8'hAA;  // R8 bits 1,3,5,7 (msb is bit 1)
                2'b10:   r = d ^ 8'h55;  // R8 bits 2,4,6,8
                2'b11:   r = ~d;         // R9
                default: r = d;          // R8
            endcase
        end else if (!c.manip_select_zero) begin
            r = idle;                    // R10 R15 msb leaves first
        end else begin
            r = mw_byte(c.manip_select_one, ph); // R11 R12
        end
        return r;
    endfunction : manip

    ////////////////////////////////////////////////////////////////////////
    // registers and per-slot store
    logic [7:0]  addr_ctl_reg;
    logic [7:0]  data_buf_reg;
    logic        indirect_mode_select;
    logic        per_slot_function_enable;
    logic [7:0]  ctrl_mem [SLOTS];
    logic [7:0]  idle_mem [SLOTS];
    ptc_acc_t    acc_reg;
    logic [3:0]  acc_cnt_reg;
    logic        busy;
    logic [6:0]  ia;
    logic [4:0]  ia_slot;
    logic        ia_ctrl;
    logic        ia_idle;

    assign busy    = acc_reg != PTC_IDLE;                        // R18
    assign ia      = addr_ctl_reg[6:0];                          // R1
    assign ia_slot = ia[4:0];
    assign ia_ctrl = in_win(ia, `PTC_CTRL_BASE, `PTC_CTRL_END); // R5
    assign ia_idle = in_win(ia, `PTC_IDLE_BASE, `PTC_IDLE_END); // R6

    // host registers; request starts only in indirect mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ctl_reg             <= `PTC_REG_RESET; // R16
            indirect_mode_select     <= 1'b0;           // R19
            per_slot_function_enable <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `PTC_OFS_ADDR) addr_ctl_reg <= reg_wdata;
            if (reg_addr == `PTC_OFS_CFG) begin
                indirect_mode_select     <= reg_wdata[1];
                per_slot_function_enable <= reg_wdata[0];
            end
        end
    end

    // access sequencer, fixed length inside the 480 ns budget
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg     <= PTC_IDLE;
            acc_cnt_reg <= 4'h0;
        end else begin
            case (acc_reg)
                PTC_IDLE: begin
                    if (reg_wr && reg_addr == `PTC_OFS_ADDR && indirect_mode_select) begin
                        acc_reg     <= PTC_RUN; // R2
                        acc_cnt_reg <= 4'h0;
                    end
                end
                PTC_RUN: begin
                    acc_cnt_reg <= acc_cnt_reg + 4'h1;
                    if (acc_cnt_reg == 4'(ACC_CYC - 3)) acc_reg <= PTC_DONE;
                end
                PTC_DONE: acc_reg <= PTC_IDLE;
                default:  acc_reg <= PTC_IDLE;
            endcase
        end
    end

    // data buffer: host write or read result at completion
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_buf_reg <= `PTC_REG_RESET; // R16
        end else if (acc_reg == PTC_DONE && addr_ctl_reg[`PTC_DIR_BIT]) begin
            if (ia_ctrl)      data_buf_reg <= ctrl_mem[ia[4:0]]; // R4
            else if (ia_idle) data_buf_reg <= idle_mem[ia[4:0]]; // R4
            else              data_buf_reg <= 8'h00;
        end else if (reg_wr && reg_addr == `PTC_OFS_DATA) begin
            data_buf_reg <= reg_wdata; // R3
        end
    end

    // store write from buffer at completion; contents not reset
    always_ff @(posedge clk) begin
        if (acc_reg == PTC_DONE && !addr_ctl_reg[`PTC_DIR_BIT]) begin
            if (ia_ctrl) ctrl_mem[ia[4:0]] <= data_buf_reg; // R5 R7
            if (ia_idle) idle_mem[ia[4:0]] <= data_buf_reg; // R6
        end
    end

    // read mux, registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PTC_OFS_CFG:    reg_rdata <= {6'h00, indirect_mode_select, per_slot_function_enable};
                `PTC_OFS_STATUS: reg_rdata <= {busy, 7'h00}; // R18
                `PTC_OFS_ADDR:   reg_rdata <= addr_ctl_reg;
                `PTC_OFS_DATA:   reg_rdata <= data_buf_reg;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath: slot counter, manipulation, output fifo
    logic [4:0]  slot_reg;
    logic [2:0]  mw_phase_reg [SLOTS];
    logic        take;
    logic [4:0]  cur_slot;
    ptc_ctrl_t   cur_ctrl;
    ptc_slot_t   cur_out;
    ptc_slot_t   fifo_out;
    logic        fifo_valid;

    assign take     = slot_valid && slot_ready;
    assign cur_slot = frame_start ? 5'h00 : slot_reg; // R20
    assign cur_ctrl = ptc_ctrl_t'(ctrl_mem[cur_slot]);

    // manipulation applied only with per-slot enable
    always_comb begin
        cur_out.pcm = backplane_tx_pcm_in;
        cur_out.sig = backplane_tx_signalling_in;
        if (per_slot_function_enable) begin // R17
            cur_out.pcm = manip(cur_ctrl, backplane_tx_pcm_in, idle_mem[cur_slot],
                                mw_phase_reg[cur_slot]);
            if (cas_mode && cur_ctrl.signalling_source_select) // R13
                cur_out.sig = cur_ctrl.alt_sig; // R14
        end
    end

    // slot counter tracks frame alignment
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) slot_reg <= 5'h00;
        else if (take) slot_reg <= cur_slot + 5'h01; // R20 wraps at 32
    end

    // milliwatt phase per slot, one step per frame
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < SLOTS; i++) mw_phase_reg[i] <= 3'h0;
        end else if (take) begin
            mw_phase_reg[cur_slot] <= mw_phase_reg[cur_slot] + 3'h1; // R11 R12
        end
    end

    // fifo absorbs transmitter stalls; its ready back-pressures the source
    ptc_fifo #(.WIDTH(12), .DEPTH(32)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (slot_valid),
        .in_ready  (slot_ready),
        .in_data   (cur_out),
        .out_valid (fifo_valid),
        .out_ready (!tx_valid || tx_ready),
        .out_data  (fifo_out)
    );

    // output register stage, tx_slot counts output words modulo 32
    logic [4:0] fifo_slot_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_valid      <= 1'b0;
            tx_pcm_stream <= 8'h00;
            tx_sig_stream <= 4'h0;
            tx_slot       <= 5'h00;
            fifo_slot_reg <= 5'h00;
        end else if (!tx_valid || tx_ready) begin
            tx_valid <= fifo_valid;
            if (fifo_valid) begin
                tx_pcm_stream <= fifo_out.pcm;
                tx_sig_stream <= fifo_out.sig;
                tx_slot       <= fifo_slot_reg;
                fifo_slot_reg <= fifo_slot_reg + 5'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [3:0] busy_cnt;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) busy_cnt <= 4'h0;
        else if (busy) busy_cnt <= busy_cnt + 4'h1;
        else busy_cnt <= 4'h0;
    end

    busy_bound_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        busy_cnt < 4'(ACC_CYC)) else $error("access exceeds 480 ns");
    start_busy_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
        (reg_wr && reg_addr == `PTC_OFS_ADDR && indirect_mode_select && !busy) |=> busy)
        else $error("access did not start");
    no_mode_a: assert property (@(posedge clk) disable iff (sys_rst) // R19
        (!indirect_mode_select && !busy) |=> !busy) else $error("access without indirect mode");
    busy_done_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
        $rose(busy) |-> busy [*8] ##[1:5] !busy) else $error("busy length wrong");
    pass_off_a: assert property (@(posedge clk) disable iff (sys_rst) // R17
        !per_slot_function_enable |-> cur_out.pcm == backplane_tx_pcm_in)
        else $error("manipulation while disabled");
    inv_all_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b011)
        |-> cur_out.pcm == ~backplane_tx_pcm_in) else $error("full inversion wrong");
    idle_sub_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        (per_slot_function_enable && cur_ctrl[7:6] == 2'b10)
        |-> cur_out.pcm == idle_mem[cur_slot]) else $error("idle substitution wrong");
    sig_ign_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
        !cas_mode |-> cur_out.sig == backplane_tx_signalling_in) else $error("signalling source without cas");
    read_land_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (acc_reg == PTC_DONE && addr_ctl_reg[7] && ia_idle)
        |=> data_buf_reg == idle_mem[$past(ia_slot)]) else $error("read data missing");
    read_ctrl_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        (acc_reg == PTC_DONE && addr_ctl_reg[7] && ia_ctrl)
        |=> data_buf_reg == ctrl_mem[$past(ia_slot)]) else $error("control read missing");
    write_land_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
        (acc_reg == PTC_DONE && !addr_ctl_reg[7] && ia_ctrl)
        |=> ctrl_mem[$past(ia_slot)] == $past(data_buf_reg)) else $error("control write lost");

    // host register side
    addr_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (reg_wr && reg_addr == `PTC_OFS_ADDR) |=> addr_ctl_reg == $past(reg_wdata))
        else $error("address register not written");
    buf_write_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
        (reg_wr && reg_addr == `PTC_OFS_DATA && !(acc_reg == PTC_DONE && addr_ctl_reg[7]))
        |=> data_buf_reg == $past(reg_wdata)) else $error("data buffer not written");
    rdata_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");

    // byte manipulation with substitution off
    pass_on_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b000)
        |-> cur_out.pcm == backplane_tx_pcm_in) else $error("pass through altered byte");
    adi_odd_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b001)
        |-> cur_out.pcm == (backplane_tx_pcm_in ^ 8'hAA)) else $error("odd bit inversion wrong");
    adi_even_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b010)
        |-> cur_out.pcm == (backplane_tx_pcm_in ^ 8'h55)) else $error("even bit inversion wrong");

    // milliwatt patterns, checked against literal bytes at known phases
    mw_alaw_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b110 && mw_phase_reg[cur_slot] == 3'h0)
        |-> cur_out.pcm == 8'h34) else $error("a-law first byte wrong");
    mw_alaw_b_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b110 && mw_phase_reg[cur_slot] == 3'h1)
        |-> cur_out.pcm == 8'h21) else $error("a-law second byte wrong");
    mw_ulaw_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b111 && mw_phase_reg[cur_slot] == 3'h0)
        |-> cur_out.pcm == 8'h1E) else $error("mu-law first byte wrong");
    mw_ulaw_b_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
        (per_slot_function_enable && cur_ctrl[7:5] == 3'b111 && mw_phase_reg[cur_slot] == 3'h1)
        |-> cur_out.pcm == 8'h0B) else $error("mu-law second byte wrong");

    // signalling source under cas
    sig_alt_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
        (per_slot_function_enable && cas_mode && cur_ctrl[4])
        |-> cur_out.sig == cur_ctrl[3:0]) else $error("alternate signalling not used");
    sig_bp_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
        (cas_mode && !cur_ctrl[4]) |-> cur_out.sig == backplane_tx_signalling_in)
        else $error("backplane signalling not used");

    // slot alignment and output holding
    slot_step_a: assert property (@(posedge clk) disable iff (sys_rst) // R20
        take |=> slot_reg == $past(cur_slot) + 5'h01) else $error("slot counter did not step");
    frame_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // R20
        (take && frame_start) |=> slot_reg == 5'h01) else $error("frame start not aligned");
    tx_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R20
        (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_pcm_stream) && $stable(tx_sig_stream)))
        else $error("output word dropped while stalled");

    read_cov_c:  cover property (@(posedge clk) acc_reg == PTC_DONE && addr_ctl_reg[7]);
    write_cov_c: cover property (@(posedge clk) acc_reg == PTC_DONE && !addr_ctl_reg[7]);
    mw_cov_c:    cover property (@(posedge clk) take && cur_ctrl[7:6] == 2'b11);
    stall_cov_c: cover property (@(posedge clk) slot_valid && !slot_ready);
    idle_cov_c:  cover property (@(posedge clk) take && cur_ctrl[7:6] == 2'b10);
endmodule : ptc_top

// File: ptc_sink.sv
`timescale 1ns/1ps
module ptc_sink (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // pacing chosen by the bench
    input  wire logic       stall,
    input  wire logic       slow,
    // manipulated stream from the block
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_pcm_stream,
    input  wire logic [3:0] tx_sig_stream
);
    logic [11:0] got[$];
    logic        tick;
    // slow mode takes every other cycle so the block must hold its word
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick <= 1'b0;
        end else begin
            tick <= ~tick;
        end
    end
    assign tx_ready = !stall && (!slow || tick);
    // keep every accepted word for the bench to compare
    always @(posedge clk) begin
        if (!sys_rst && tx_valid && tx_ready) begin
            got.push_back({tx_pcm_stream, tx_sig_stream});
        end
    end
endmodule : ptc_sink

// File: tb.sv
`timescale 1ns/1ps
module tb;
    import ptc_pkg::*;
    logic       clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, cas_mode = 0, stall = 0, slow = 0;
    logic       slot_valid = 0, frame_start = 0, slot_ready, tx_valid, tx_ready;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, pcm_in = 0, tx_pcm, v;
    logic [3:0] sig_in = 0, tx_sig;
    logic [4:0] tx_slot;
    int         n_fail = 0, comparisons = 0, cyc = 0, t0, n;
    logic [11:0] exp_q[$];
    logic [4:0] exp_slot = 5'h00;
    logic [7:0] mw_a [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
    logic [7:0] mw_u [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
    logic [7:0] ctrl [8] = '{8'h1C, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hD3, 8'hE0};

    ptc_top uut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cas_mode(cas_mode), .slot_valid(slot_valid),
        .slot_ready(slot_ready), .frame_start(frame_start), .backplane_tx_pcm_in(pcm_in),
        .backplane_tx_signalling_in(sig_in), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_pcm_stream(tx_pcm), .tx_sig_stream(tx_sig), .tx_slot(tx_slot));
    ptc_sink partner (.clk(clk), .sys_rst(sys_rst), .stall(stall), .slow(slow), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_pcm_stream(tx_pcm), .tx_sig_stream(tx_sig));

    // 25 MHz clock and a cycle ceiling well above the expected run
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            results();
        end
    end
    // output word index counts accepted words modulo 32
    always @(posedge clk) begin
        if (!sys_rst && tx_valid && tx_ready) begin
            chk({7'h00, tx_slot}, {7'h00, exp_slot});
            exp_slot <= exp_slot + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [11:0] got, input logic [11:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // start an indirect access and poll busy until it drops
    task indir(input logic [7:0] a);
        logic [7:0] s;
        s = 8'h80;
        wr(8'h32, a);
        t0 = cyc;
        for (int i = 0; i < 20 && s[7] !== 1'b0; i++) rd(8'h31, s);
        chk({11'h0, s[7]}, 12'h0);
        chk(12'(cyc - t0 <= 14), 12'h1);
    endtask : indir
    task iwr(input logic [6:0] a, input logic [7:0] d);
        wr(8'h33, d);
        indir({1'b0, a});
    endtask : iwr
    task ird(input logic [6:0] a, input logic [7:0] e);
        indir({1'b1, a});
        rd(8'h33, v);
        chk({4'h0, v}, {4'h0, e});
    endtask : ird
    // hold the word until the accepting edge; back to back words allowed
    task push(input logic [7:0] p, input logic [3:0] s, input logic fs);
        slot_valid <= 1'b1;
        pcm_in <= p;
        sig_in <= s;
        frame_start <= fs;
        #1;
        while (slot_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
    endtask : push
    // released lines show the inverse rather than the last value
    task release_src;
        slot_valid <= 1'b0;
        frame_start <= 1'b0;
        pcm_in <= ~pcm_in;
        sig_in <= ~sig_in;
    endtask : release_src
    task frame(input int ph, input logic en, input logic cas);
        logic [7:0] p, c, e;
        logic [3:0] s;
        @(posedge clk);
        cas_mode <= cas;
        for (int k = 0; k < 8; k++) begin
            p = 8'h3C + 8'(k);
            s = 4'h9 + 4'(k);
            c = ctrl[k];
            case (c[7:5])
                3'b000: e = p;
                3'b001: e = p ^ 8'hAA;
                3'b010: e = p ^ 8'h55;
                3'b011: e = ~p;
                3'b110: e = mw_a[ph];
                3'b111: e = mw_u[ph];
                default: e = 8'h90 + 8'(k);
            endcase
            if (!en) e = p;
            exp_q.push_back({e, (en && cas && c[4]) ? c[3:0] : s});
            push(p, s, k == 0);
        end
        release_src();
    endtask : frame
    task drain;
        for (int i = 0; i < 400 && partner.got.size() < exp_q.size(); i++) @(posedge clk);
        chk(12'(partner.got.size()), 12'(exp_q.size()));
        while (partner.got.size() > 0 && exp_q.size() > 0) chk(partner.got.pop_front(), exp_q.pop_front());
    endtask : drain
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h32, v);
        chk({4'h0, v}, 12'h0);
        rd(8'h33, v);
        chk({4'h0, v}, 12'h0);
        wr(8'h30, 8'h03);
        for (int k = 0; k < 8; k++) begin
            iwr(7'h20 + 7'(k), ctrl[k]);
            iwr(7'h40 + 7'(k), 8'h90 + 8'(k));
        end
        iwr(7'h3F, 8'h5A);
        iwr(7'h5F, 8'hC3);
        ird(7'h26, 8'hD3);
        ird(7'h3F, 8'h5A);
        ird(7'h45, 8'h95);
        ird(7'h5F, 8'hC3);
        frame(0, 1'b1, 1'b1);
        slow <= 1'b1;
        frame(1, 1'b1, 1'b0);
        drain();
        // stalled consumer: fill the buffer until it refuses
        wr(8'h30, 8'h02);
        stall <= 1'b1;
        @(posedge clk);
        n = 0;
        while (n < 40) begin
            slot_valid <= 1'b1;
            pcm_in <= 8'(n);
            sig_in <= 4'(n);
            frame_start <= (n % 8 == 0);
            #1;
            if (slot_ready !== 1'b1) break;
            exp_q.push_back({8'(n), 4'(n)});
            n++;
            @(posedge clk);
        end
        chk({11'h0, slot_ready}, 12'h0);
        chk(12'(n >= 32 && n <= 34), 12'h1);
        @(posedge clk);
        release_src();
        stall <= 1'b0;
        drain();
        results();
    end
endmodule : tb
